// [rtl/fault_sup_pkg.sv]
// constants shared by the backlight fault supervisor
package fault_sup_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  // flag bit positions in status, clear and enable
  localparam int FL_VIN_UV = 0;
  localparam int FL_VIN_OV = 1;
  localparam int FL_VDD_UV = 2;
  localparam int FL_VIN_OC = 3;
  localparam int FL_CP_FAULT = 4;
  localparam int FL_CP_MISSING = 5;
  localparam int FL_SYNC_INVALID = 6;
  localparam int FL_CFG_LOAD = 7;
  localparam int FL_BST_OV_LOW = 8;
  localparam int FL_BST_OV_HIGH = 9;
  localparam int FL_BST_OC = 10;
  localparam int FL_LED_STRAP = 11;
  localparam int FL_MODE_STRAP = 12;
  localparam int FL_FREQ_STRAP = 13;
  localparam int NUM_FLAGS = 14;
  // flags that may drive the interrupt at all
  localparam logic [13:0] IRQ_CAPABLE = 14'h06FF;
  localparam logic [13:0] ENABLE_RESET = 14'h3FFF;
  // state register fields
  localparam int ST_LSB = 0;
  localparam int EXT_SYNC_BIT = 2;
  localparam int FALLBACK_BIT = 3;
  localparam int CP_ON_BIT = 4;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOVERY_MS = 100;
  localparam int BST_OC_PERSIST_MS = 110;
  localparam int SYNC_MIN_KHZ = 75;
  localparam int NS_PER_MS = 1000000;
  localparam int RECOVERY_CYC = RECOVERY_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int BST_OC_CYC = BST_OC_PERSIST_MS * NS_PER_MS / CLK_PERIOD_NS;
  // longest sync period, rounded down to whole cycles
  localparam int SYNC_TIMEOUT_CYC = (NS_PER_MS / SYNC_MIN_KHZ) / CLK_PERIOD_NS;
  localparam int SYNC_CNT_W = 11;
  // fallback configuration
  localparam logic [2:0] DEF_LED_CHANNELS = 3'h6;
  localparam logic [7:0] DEF_LED_CURRENT_MA = 8'hC8;
  localparam logic [6:0] DEF_BUS_ADDR = 7'h2A;
  localparam logic [11:0] DEF_BOOST_KHZ = 12'h190;
  localparam logic [11:0] DEF_DIM_HZ = 12'h131;
  typedef enum logic [1:0] {
    ST_INIT,
    ST_STANDBY,
    ST_RUN,
    ST_RECOVER
  } sup_state_type;
endpackage

// [rtl/fault_timer.sv]
// persistence timer: counts while run is high, clears when it drops
`timescale 1ns/1ps
`default_nettype none
module fault_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // control
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  // status
  output logic o_done
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  assign o_done = i_run && (count_q == i_limit);

  always_comb
  begin
    count_d = count_q;
    if (!i_run)
      count_d = '0;
    else if (count_q != i_limit)
      count_d = count_q + W'(1);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      count_q <= '0;
    else if (i_ce)
      count_q <= count_d;
  end
endmodule
`default_nettype wire

// [rtl/backlight_fault_supervisor.sv]
// fault supervisor for a backlight driver with boost controller
// What this block does
// RQ1: input undervoltage: flag, irq, recovery, wait clear
// RQ2: input overvoltage: flag, irq, recovery, wait clear
// RQ3: logic supply low: flag, irq, standby only
// RQ4: input overcurrent or pump fault: recover 100ms
// RQ5: pump parts missing: disable pump, report both
// RQ6: lost sync clock: flag, irq, internal frequency
// RQ7: after fallback spread spectrum follows sync level
// RQ8: config load error: flag, irq, keep running
// RQ9: boost low overvoltage: flag only, pause switching
// RQ10: boost high overvoltage: irq, recover, wait clear
// RQ11: feedback low 110ms: overcurrent flag, recover
// RQ12: bad led strap: flag, six channels 200mA
// RQ13: bad mode strap: flag, phase shift, 0x2A
// RQ14: bad frequency strap: flag, 400kHz, 305Hz
// RQ15: recovery holds switch, boost, drivers off 100ms, then restart
// RQ16: standby goes straight on when no fault
// RQ17: software clears flags; new faults set again
// RQ18: irq stays high while enabled irq-capable flag set
`timescale 1ns/1ps
`default_nettype none
module backlight_fault_supervisor #(
  parameter int TIMER_W = 24,
  parameter int RECOVERY_CYC = fault_sup_pkg::RECOVERY_CYC,
  parameter int BST_OC_CYC = fault_sup_pkg::BST_OC_CYC
) (
  // clock, reset, clock enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // device control
  input wire logic i_init_done,
  input wire logic i_enable,
  input wire logic i_brightness_nonzero,
  // fault comparators
  input wire logic i_vin_undervoltage,
  input wire logic i_vin_overvoltage,
  input wire logic i_logic_supply_undervoltage,
  input wire logic i_vin_overcurrent,
  input wire logic i_charge_pump_abnormal,
  input wire logic i_charge_pump_missing,
  input wire logic i_config_load_error,
  input wire logic i_boost_overvoltage_low,
  input wire logic i_boost_overvoltage_high,
  input wire logic i_boost_feedback_input_low,
  input wire logic i_boost_sync_input,
  // straps, sampled once when init completes
  input wire logic i_led_config_strap_ok,
  input wire logic [2:0] i_led_config_channels,
  input wire logic [7:0] i_led_config_current_ma,
  input wire logic i_mode_strap_ok,
  input wire logic i_mode_phase_shift,
  input wire logic [6:0] i_mode_bus_address,
  input wire logic i_boost_frequency_strap_ok,
  input wire logic [11:0] i_boost_frequency_khz,
  input wire logic i_dimming_frequency_strap_ok,
  input wire logic [11:0] i_dimming_frequency_hz,
  // power stage control
  output logic o_led_enable,
  output logic o_boost_enable,
  output logic o_power_switch_enable,
  output logic o_charge_pump_enable,
  output logic o_use_external_sync,
  output logic o_spread_spectrum,
  // chosen configuration
  output logic [2:0] o_led_channels,
  output logic [7:0] o_led_current_ma,
  output logic o_phase_shift_mode,
  output logic [6:0] o_bus_address,
  output logic [11:0] o_boost_freq_khz,
  output logic [11:0] o_dimming_freq_hz,
  // interrupt
  output logic o_fault_irq
);
  localparam int NF = fault_sup_pkg::NUM_FLAGS;
  localparam logic [fault_sup_pkg::SYNC_CNT_W-1:0] SYNC_LIMIT =
    fault_sup_pkg::SYNC_CNT_W'(fault_sup_pkg::SYNC_TIMEOUT_CYC);

  // reset release through two flops
  logic rst_meta_q;
  logic rstn;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_q <= 1'b0;
      rstn <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rstn <= rst_meta_q;
    end
  end

  // state
  fault_sup_pkg::sup_state_type state_q;
  fault_sup_pkg::sup_state_type state_d;
  logic [NF-1:0] status_q;
  logic [NF-1:0] status_d;
  logic [NF-1:0] enable_q;
  logic [NF-1:0] enable_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic cp_on_q;
  logic cp_on_d;
  logic sync_prev_q;
  logic sync_seen_q;
  logic sync_seen_d;
  logic [fault_sup_pkg::SYNC_CNT_W-1:0] sync_cnt_q;
  logic [fault_sup_pkg::SYNC_CNT_W-1:0] sync_cnt_d;
  logic ext_sync_q;
  logic ext_sync_d;
  logic fallback_q;
  logic fallback_d;
  logic [2:0] led_ch_q;
  logic [2:0] led_ch_d;
  logic [7:0] led_ma_q;
  logic [7:0] led_ma_d;
  logic phase_q;
  logic phase_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic [11:0] bst_khz_q;
  logic [11:0] bst_khz_d;
  logic [11:0] dim_hz_q;
  logic [11:0] dim_hz_d;

  logic recover_done;
  logic bst_oc_expired;
  logic sync_edge;
  logic sync_alive;
  logic sync_lost;
  logic recover_fault;
  logic standby_hold;
  logic init_step;
  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  logic [NF-1:0] clear_mask;
  logic [NF-1:0] events;

  // restart delay counted from entry into the recovery state
  fault_timer #(.W(TIMER_W)) u_recover_timer (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_ce(i_ce),
    .i_run(state_q == fault_sup_pkg::ST_RECOVER),
    .i_limit(TIMER_W'(RECOVERY_CYC - 1)),
    .o_done(recover_done)
  );

  // feedback under-voltage must persist before it counts
  fault_timer #(.W(TIMER_W)) u_bst_oc_timer (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_ce(i_ce),
    .i_run((state_q == fault_sup_pkg::ST_RUN) &&
           i_boost_feedback_input_low),
    .i_limit(TIMER_W'(BST_OC_CYC - 1)),
    .o_done(bst_oc_expired) // RQ11
  );

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == fault_sup_pkg::ADDR_STATUS) ||
                (a == fault_sup_pkg::ADDR_CLEAR) ||
                (a == fault_sup_pkg::ADDR_ENABLE) ||
                (a == fault_sup_pkg::ADDR_STATE);
  endfunction

  // apb decode; zero wait states
  assign addr_ok = is_mapped(i_paddr);
  assign wr_access = i_psel && i_penable && i_pwrite && addr_ok;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_prdata = prdata_q;
  assign init_step = (state_q == fault_sup_pkg::ST_INIT) && i_init_done;

  // sync clock monitor
  assign sync_edge = i_boost_sync_input && !sync_prev_q;
  assign sync_alive = sync_seen_q && (sync_cnt_q != SYNC_LIMIT);
  assign sync_lost = ext_sync_q && !sync_alive; // RQ6

  // faults that force the recovery state
  assign recover_fault = i_vin_undervoltage || // RQ1
                         i_vin_overvoltage || // RQ2
                         i_vin_overcurrent || // RQ4
                         i_charge_pump_abnormal || // RQ4
                         i_boost_overvoltage_high || // RQ10
                         bst_oc_expired; // RQ11

  // levels that block any restart while present
  assign standby_hold = i_vin_undervoltage || // RQ1
                        i_vin_overvoltage || // RQ2
                        i_logic_supply_undervoltage || // RQ3
                        i_boost_overvoltage_high; // RQ10

  always_comb
  begin
    events = '0;
    events[fault_sup_pkg::FL_VIN_UV] = i_vin_undervoltage; // RQ1
    events[fault_sup_pkg::FL_VIN_OV] = i_vin_overvoltage; // RQ2
    events[fault_sup_pkg::FL_VDD_UV] = i_logic_supply_undervoltage; // RQ3
    events[fault_sup_pkg::FL_VIN_OC] = i_vin_overcurrent; // RQ4
    // a missing part is also reported as a pump fault
    events[fault_sup_pkg::FL_CP_FAULT] = i_charge_pump_abnormal ||
                                         i_charge_pump_missing; // RQ5
    events[fault_sup_pkg::FL_CP_MISSING] = i_charge_pump_missing; // RQ5
    events[fault_sup_pkg::FL_SYNC_INVALID] = sync_lost; // RQ6
    events[fault_sup_pkg::FL_CFG_LOAD] = i_config_load_error; // RQ8
    events[fault_sup_pkg::FL_BST_OV_LOW] = i_boost_overvoltage_low; // RQ9
    events[fault_sup_pkg::FL_BST_OV_HIGH] = i_boost_overvoltage_high;
    events[fault_sup_pkg::FL_BST_OC] = bst_oc_expired; // RQ11
    // straps are judged once, when init completes
    events[fault_sup_pkg::FL_LED_STRAP] =
      init_step && !i_led_config_strap_ok; // RQ12
    events[fault_sup_pkg::FL_MODE_STRAP] =
      init_step && !i_mode_strap_ok; // RQ13
    events[fault_sup_pkg::FL_FREQ_STRAP] = init_step &&
      !(i_boost_frequency_strap_ok && i_dimming_frequency_strap_ok);
  end

  // status, clear and enable registers
  always_comb
  begin
    clear_mask = '0;
    enable_d = enable_q;
    if (wr_access && (i_paddr == fault_sup_pkg::ADDR_CLEAR))
      clear_mask = i_pwdata[NF-1:0]; // RQ17
    if (wr_access && (i_paddr == fault_sup_pkg::ADDR_ENABLE))
      enable_d = i_pwdata[NF-1:0];
    // a new event in the clearing cycle still sets its flag
    status_d = (status_q & ~clear_mask) | events; // RQ17
    prdata_d = prdata_q;
    if (rd_setup)
    begin
      prdata_d = '0;
      case (i_paddr)
        fault_sup_pkg::ADDR_STATUS: prdata_d[NF-1:0] = status_q;
        fault_sup_pkg::ADDR_ENABLE: prdata_d[NF-1:0] = enable_q;
        fault_sup_pkg::ADDR_STATE:
        begin
          prdata_d[fault_sup_pkg::ST_LSB +: 2] = state_q;
          prdata_d[fault_sup_pkg::EXT_SYNC_BIT] = ext_sync_q;
          prdata_d[fault_sup_pkg::FALLBACK_BIT] = fallback_q;
          prdata_d[fault_sup_pkg::CP_ON_BIT] = cp_on_q;
        end
        default: prdata_d = '0;
      endcase
    end
  end

  // level interrupt; strap and low-ovp flags never reach it
  assign o_fault_irq =
    |(status_q & enable_q & fault_sup_pkg::IRQ_CAPABLE); // RQ18

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_q <= '0;
      enable_q <= fault_sup_pkg::ENABLE_RESET;
      prdata_q <= '0;
    end
    else if (i_ce)
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      prdata_q <= prdata_d;
    end
  end

  // supervisor state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fault_sup_pkg::ST_INIT:
        if (i_init_done)
          state_d = fault_sup_pkg::ST_STANDBY;
      fault_sup_pkg::ST_STANDBY:
        if (recover_fault)
          state_d = fault_sup_pkg::ST_RECOVER;
        else if (!standby_hold && i_enable &&
                 i_brightness_nonzero)
          state_d = fault_sup_pkg::ST_RUN; // RQ16
      fault_sup_pkg::ST_RUN:
        if (recover_fault)
          state_d = fault_sup_pkg::ST_RECOVER; // RQ4
        else if (i_logic_supply_undervoltage || !i_enable)
          state_d = fault_sup_pkg::ST_STANDBY; // RQ3
      fault_sup_pkg::ST_RECOVER:
        // the delay runs out first, then held-off levels must clear
        if (recover_done && !standby_hold)
          state_d = fault_sup_pkg::ST_STANDBY; // RQ15
      default: state_d = fault_sup_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= fault_sup_pkg::ST_INIT;
    else if (i_ce)
      state_q <= state_d;
  end

  // drivers, boost and line switch only run in the run state
  assign o_power_switch_enable =
    (state_q == fault_sup_pkg::ST_RUN); // RQ15
  assign o_boost_enable = (state_q == fault_sup_pkg::ST_RUN) &&
    !i_boost_overvoltage_low; // RQ9
  assign o_led_enable = (state_q == fault_sup_pkg::ST_RUN) &&
    i_brightness_nonzero; // RQ15
  assign o_charge_pump_enable = cp_on_q;

  // sync monitor and fallback
  always_comb
  begin
    sync_seen_d = sync_seen_q;
    sync_cnt_d = sync_cnt_q;
    ext_sync_d = ext_sync_q;
    fallback_d = fallback_q;
    if (sync_edge)
    begin
      sync_seen_d = 1'b1;
      sync_cnt_d = '0;
    end
    else if (sync_cnt_q != SYNC_LIMIT)
      sync_cnt_d = sync_cnt_q + 1'b1;
    // external sync only adopted if alive at enable time
    if (state_q == fault_sup_pkg::ST_STANDBY && state_d ==
        fault_sup_pkg::ST_RUN && sync_alive && !fallback_q)
      ext_sync_d = 1'b1;
    if (sync_lost)
    begin
      ext_sync_d = 1'b0; // RQ6
      fallback_d = 1'b1; // RQ7
    end
    if (!i_enable)
    begin
      ext_sync_d = 1'b0;
      fallback_d = 1'b0;
    end
  end

  assign o_use_external_sync = ext_sync_q;
  // no sync means the held level picks spread spectrum
  assign o_spread_spectrum = fallback_q && i_boost_sync_input; // RQ7

  // pump stays off once parts are found missing
  assign cp_on_d = cp_on_q && !i_charge_pump_missing; // RQ5

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_prev_q <= 1'b0;
      sync_seen_q <= 1'b0;
      sync_cnt_q <= '0;
      ext_sync_q <= 1'b0;
      fallback_q <= 1'b0;
      cp_on_q <= 1'b1;
    end
    else if (i_ce)
    begin
      sync_prev_q <= i_boost_sync_input;
      sync_seen_q <= sync_seen_d;
      sync_cnt_q <= sync_cnt_d;
      ext_sync_q <= ext_sync_d;
      fallback_q <= fallback_d;
      cp_on_q <= cp_on_d;
    end
  end

  // strap capture with defaults for bad straps
  always_comb
  begin
    led_ch_d = led_ch_q;
    led_ma_d = led_ma_q;
    phase_d = phase_q;
    addr_d = addr_q;
    bst_khz_d = bst_khz_q;
    dim_hz_d = dim_hz_q;
    if (init_step)
    begin
      led_ch_d = i_led_config_strap_ok ? i_led_config_channels :
                 fault_sup_pkg::DEF_LED_CHANNELS; // RQ12
      led_ma_d = i_led_config_strap_ok ? i_led_config_current_ma :
                 fault_sup_pkg::DEF_LED_CURRENT_MA; // RQ12
      phase_d = i_mode_strap_ok ? i_mode_phase_shift : 1'b1; // RQ13
      addr_d = i_mode_strap_ok ? i_mode_bus_address :
               fault_sup_pkg::DEF_BUS_ADDR; // RQ13
      bst_khz_d = i_boost_frequency_strap_ok ? i_boost_frequency_khz :
                  fault_sup_pkg::DEF_BOOST_KHZ; // RQ14
      dim_hz_d = i_dimming_frequency_strap_ok ? i_dimming_frequency_hz :
                 fault_sup_pkg::DEF_DIM_HZ; // RQ14
    end
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      led_ch_q <= fault_sup_pkg::DEF_LED_CHANNELS;
      led_ma_q <= fault_sup_pkg::DEF_LED_CURRENT_MA;
      phase_q <= 1'b1;
      addr_q <= fault_sup_pkg::DEF_BUS_ADDR;
      bst_khz_q <= fault_sup_pkg::DEF_BOOST_KHZ;
      dim_hz_q <= fault_sup_pkg::DEF_DIM_HZ;
    end
    else if (i_ce)
    begin
      led_ch_q <= led_ch_d;
      led_ma_q <= led_ma_d;
      phase_q <= phase_d;
      addr_q <= addr_d;
      bst_khz_q <= bst_khz_d;
      dim_hz_q <= dim_hz_d;
    end
  end

  assign o_led_channels = led_ch_q;
  assign o_led_current_ma = led_ma_q;
  assign o_phase_shift_mode = phase_q;
  assign o_bus_address = addr_q;
  assign o_boost_freq_khz = bst_khz_q;
  assign o_dimming_freq_hz = dim_hz_q;
endmodule
`default_nettype wire

// [tb/fault_front.sv]
// comparator and sync clock model facing the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module fault_front (
  // clock and requested levels
  input wire logic i_clk,
  input wire logic [9:0] i_lvl,
  input wire logic i_sync_run,
  input wire logic i_sync_idle,
  // comparator outputs and sync pin
  output logic [9:0] o_cmp,
  output logic o_sync
);
  logic [5:0] div_q = 6'h00;
  initial o_cmp = 10'h000;
  initial o_sync = 1'b0;
  // comparators settle one cycle after the analog event
  always @(posedge i_clk)
  begin
    o_cmp <= i_lvl;
    div_q <= (div_q == 6'h31) ? 6'h00 : div_q + 6'h01;
    // 1 MHz sync clock, well above the 75 kHz limit
    if (!i_sync_run)
      o_sync <= i_sync_idle;
    else if (div_q == 6'h31)
      o_sync <= ~o_sync;
  end
endmodule
`default_nettype wire

// [tb/fault_sup_properties.sv]
// port-level assertions for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module fault_sup_properties #(
  parameter int RECOVERY_CYC = 20
) (
  // clock, reset, bus strobes
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic i_enable,
  // comparators
  input wire logic i_vin_undervoltage,
  input wire logic i_vin_overvoltage,
  input wire logic i_logic_supply_undervoltage,
  input wire logic i_vin_overcurrent,
  input wire logic i_charge_pump_abnormal,
  input wire logic i_charge_pump_missing,
  input wire logic i_boost_overvoltage_low,
  input wire logic i_boost_overvoltage_high,
  input wire logic i_boost_sync_input,
  // outputs watched
  input wire logic o_led_enable,
  input wire logic o_boost_enable,
  input wire logic o_power_switch_enable,
  input wire logic o_charge_pump_enable,
  input wire logic o_use_external_sync,
  input wire logic o_spread_spectrum,
  input wire logic o_fault_irq
);
  // age of the last overcurrent or pump fault, read when power returns
  logic rec_q;
  logic rec_d;
  logic [31:0] age_q;
  logic [31:0] age_d;
  always_comb
  begin
    rec_d = rec_q & ~o_power_switch_enable;
    age_d = age_q + 32'h1;
    if ((i_vin_overcurrent | i_charge_pump_abnormal) & o_power_switch_enable)
    begin
      rec_d = 1'b1;
      age_d = 32'h0;
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rec_q <= 1'b0;
      age_q <= 32'h0;
    end
    else
    begin
      rec_q <= rec_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_VIN_UV_OFF: assert property (i_vin_undervoltage |=> !o_power_switch_enable)
    else $error("power on during input undervoltage");
  AST_VIN_OV_OFF: assert property (i_vin_overvoltage |=> !o_power_switch_enable)
    else $error("power on during input overvoltage");
  AST_VDD_UV_OFF: assert property (i_logic_supply_undervoltage |=> !o_power_switch_enable)
    else $error("power on during supply undervoltage");
  AST_OC_SHUTDOWN: assert property ((i_vin_overcurrent || i_charge_pump_abnormal)
    |=> !o_power_switch_enable && !o_boost_enable && !o_led_enable)
    else $error("stage not shut down after overcurrent");
  AST_RECOVERY_SPAN: assert property ($rose(o_power_switch_enable) && rec_q
    |-> age_q >= RECOVERY_CYC && age_q <= RECOVERY_CYC + 3)
    else $error("restart outside recovery window");
  AST_PUMP_OFF: assert property (i_charge_pump_missing |=> !o_charge_pump_enable ##1 !o_charge_pump_enable)
    else $error("pump on after missing part");
  AST_PUMP_STAYS: assert property (!o_charge_pump_enable |=> !o_charge_pump_enable)
    else $error("pump came back on");
  AST_OVP_LOW: assert property (i_boost_overvoltage_low |-> !o_boost_enable)
    else $error("boost on in low overvoltage");
  AST_OVP_HIGH: assert property (i_boost_overvoltage_high |=> !o_power_switch_enable)
    else $error("power on during high overvoltage");
  AST_FALLBACK_SS: assert property ($fell(o_use_external_sync) && i_enable
    |-> o_spread_spectrum == i_boost_sync_input)
    else $error("spread spectrum off sync level");
  AST_IRQ_HOLD: assert property (o_fault_irq && !(i_psel && i_penable && i_pwrite) |=> o_fault_irq)
    else $error("irq dropped without a register write");
  COV_RESTART: cover property ($rose(o_power_switch_enable) && rec_q);
  COV_FALLBACK: cover property ($fell(o_use_external_sync) && i_enable);
  COV_IRQ_CLEARED: cover property ($fell(o_fault_irq));
endmodule
bind backlight_fault_supervisor fault_sup_properties #(
  .RECOVERY_CYC(RECOVERY_CYC)
) props (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_enable,
  .i_vin_undervoltage, .i_vin_overvoltage, .i_logic_supply_undervoltage,
  .i_vin_overcurrent, .i_charge_pump_abnormal, .i_charge_pump_missing,
  .i_boost_overvoltage_low, .i_boost_overvoltage_high, .i_boost_sync_input,
  .o_led_enable, .o_boost_enable, .o_power_switch_enable,
  .o_charge_pump_enable, .o_use_external_sync, .o_spread_spectrum,
  .o_fault_irq);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the backlight fault supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, bright = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, init = 1'b0, en = 1'b0;
  logic strap_ok = 1'b0, srun = 1'b0, sidle = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic [11:0] sv = 12'h0A5, bf, df;
  logic [9:0] lv = 10'h000, cmp;
  logic pready, perr, sync, e, pwr_on, boost_on, led_on, cp_on, ext, ss, irq;
  logic ps;
  logic [2:0] chans;
  logic [7:0] cur;
  logic [6:0] baddr;
  int n_errors = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  fault_front model (.i_clk(clk), .i_lvl(lv), .i_sync_run(srun),
    .i_sync_idle(sidle), .o_cmp(cmp), .o_sync(sync));
  backlight_fault_supervisor #(.RECOVERY_CYC(20), .BST_OC_CYC(30)) dut (
    .i_clk(clk), .i_resetn(rstn), .i_ce(ce),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_init_done(init),
    .i_enable(en), .i_brightness_nonzero(bright),
    .i_vin_undervoltage(cmp[0]), .i_vin_overvoltage(cmp[1]),
    .i_logic_supply_undervoltage(cmp[2]), .i_vin_overcurrent(cmp[3]),
    .i_charge_pump_abnormal(cmp[4]), .i_charge_pump_missing(cmp[5]),
    .i_config_load_error(cmp[6]), .i_boost_overvoltage_low(cmp[7]),
    .i_boost_overvoltage_high(cmp[8]), .i_boost_feedback_input_low(cmp[9]),
    .i_boost_sync_input(sync), .i_led_config_strap_ok(strap_ok),
    .i_led_config_channels(sv[2:0]), .i_led_config_current_ma(sv[7:0]),
    .i_mode_strap_ok(strap_ok), .i_mode_phase_shift(sv[1]),
    .i_mode_bus_address(sv[6:0]), .i_boost_frequency_strap_ok(strap_ok),
    .i_boost_frequency_khz(sv), .i_dimming_frequency_strap_ok(strap_ok),
    .i_dimming_frequency_hz(sv), .o_led_enable(led_on),
    .o_boost_enable(boost_on), .o_power_switch_enable(pwr_on),
    .o_charge_pump_enable(cp_on), .o_use_external_sync(ext),
    .o_spread_spectrum(ss), .o_led_channels(chans),
    .o_led_current_ma(cur), .o_phase_shift_mode(ps),
    .o_bus_address(baddr), .o_boost_freq_khz(bf),
    .o_dimming_freq_hz(df), .o_fault_irq(irq));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic waitpwr;
    int n = 0;
    while (pwr_on !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk("power restored", 1, pwr_on);
  endtask
  task automatic clr;
    xfer(1'b1, fault_sup_pkg::ADDR_CLEAR, 32'h00003FFF);
    xfer(1'b0, fault_sup_pkg::ADDR_STATUS, 32'h0);
    chk("status cleared", 0, r);
    chk("irq released", 0, irq);
  endtask
  // raise comparator k for hold cycles, then judge flags and irq
  task automatic fault(input int k, input logic [31:0] m, input int hold,
      input logic ie, input logic off);
    lv[k] <= 1'b1;
    tick(hold);
    chk("power during fault", {31'h0, ~off}, pwr_on);
    lv[k] <= 1'b0;
    xfer(1'b0, fault_sup_pkg::ADDR_STATUS, 32'h0);
    chk("status flags", m, r);
    chk("fault irq", {31'h0, ie}, irq);
    waitpwr();
    clr();
  endtask
  task automatic t_boot;
    xfer(1'b0, fault_sup_pkg::ADDR_ENABLE, 32'h0);
    chk("enable reset", 32'h00003FFF, r);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 1, e);
    init <= 1'b1;
    en <= 1'b1;
    waitpwr();
    xfer(1'b0, fault_sup_pkg::ADDR_STATE, 32'h0);
    chk("state run", 2, r[1:0]);
    xfer(1'b0, fault_sup_pkg::ADDR_STATUS, 32'h0);
    chk("strap flags", 32'h00003800, r);
    chk("no strap irq", 0, irq);
    chk("channels", fault_sup_pkg::DEF_LED_CHANNELS, chans);
    chk("current", fault_sup_pkg::DEF_LED_CURRENT_MA, cur);
    chk("phase shift", 1, ps);
    chk("bus address", fault_sup_pkg::DEF_BUS_ADDR, baddr);
    chk("boost freq", fault_sup_pkg::DEF_BOOST_KHZ, bf);
    chk("dim freq", fault_sup_pkg::DEF_DIM_HZ, df);
    clr();
  endtask
  task automatic t_masked;
    xfer(1'b1, fault_sup_pkg::ADDR_ENABLE, 32'h0);
    lv[6] <= 1'b1;
    tick(4);
    lv[6] <= 1'b0;
    chk("load err power", 1, pwr_on);
    chk("masked irq", 0, irq);
    xfer(1'b1, fault_sup_pkg::ADDR_ENABLE, 32'h00003FFF);
    tick(1);
    chk("unmasked irq", 1, irq);
    clr();
  endtask
  task automatic t_sync;
    srun <= 1'b1;
    en <= 1'b0;
    bright <= 1'b0;
    tick(100);
    en <= 1'b1;
    tick(100);
    chk("dark start", 0, pwr_on);
    bright <= 1'b1;
    waitpwr();
    chk("sync adopted", 1, ext);
    srun <= 1'b0;
    sidle <= 1'b1;
    tick(1500);
    chk("sync dropped", 0, ext);
    chk("spread high", 1, ss);
    chk("sync irq", 1, irq);
    xfer(1'b0, fault_sup_pkg::ADDR_STATUS, 32'h0);
    chk("sync flag", 32'h00000040, r);
    sidle <= 1'b0;
    tick(3);
    chk("spread low", 0, ss);
    clr();
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(60000);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    tick(16);
    rstn <= 1'b1;
    tick(3);
    t_boot();
    fault(3, 32'h8, 4, 1'b1, 1'b1);
    fault(4, 32'h10, 4, 1'b1, 1'b1);
    fault(0, 32'h1, 40, 1'b1, 1'b1);
    fault(1, 32'h2, 40, 1'b1, 1'b1);
    fault(2, 32'h4, 40, 1'b1, 1'b1);
    fault(8, 32'h200, 40, 1'b1, 1'b1);
    fault(9, 32'h400, 35, 1'b1, 1'b1);
    fault(7, 32'h100, 4, 1'b0, 1'b0);
    t_masked();
    fault(5, 32'h30, 4, 1'b1, 1'b0);
    chk("pump disabled", 0, cp_on);
    t_sync();
    tally_and_finish();
  end
endmodule
`default_nettype wire
